// file: core_exec.sv
// How it works
// - Bit invert flips one chosen file bit
// - Bank bit zero forces the access bank
// - Overflow branch taken only when overflow set
// - Zero branch taken only when zero set
// - Taken branch target is PC plus 2 plus 2n
// - Branch one cycle, taken adds flush cycle
// - Untaken branch continues at next word
// - Call reaches any 20-bit word target
// - Call pushes address four bytes beyond
// - Shadow flag copies working, flags, bank
// - Call literal loads PC bits 20..1
// - Call two words, second cycle idle
`timescale 1ns/10ps
`default_nettype none
module core_exec import core_exec_pkg::*; (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic instr_valid,
  input wire logic [word_width-1:0] instr_word,
  input wire logic [data_width-1:0] working_register,
  input wire logic [data_width-1:0] flags_register,
  input wire logic [bank_width-1:0] bank_select_pointer,
  input wire logic [data_width-1:0] file_rdata,
  output logic [pc_width-1:0] pc,
  output logic flush,
  output logic file_we,
  output file_addr_type file_addr,
  output logic [data_width-1:0] file_wdata,
  output logic stack_push,
  output logic [pc_width-1:0] return_stack_top,
  output shadow_type shadow,
  output logic shadow_we
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  exec_state_type state_reg, state_next;
  logic [pc_width-1:0] pc_reg, pc_next;
  logic flush_reg, flush_next;
  logic file_we_reg, file_we_next;
  file_addr_type faddr_reg, faddr_next, faddr_comb;
  logic [data_width-1:0] wdata_reg, wdata_next;
  logic push_reg, push_next;
  logic [pc_width-1:0] tos_reg, tos_next;
  shadow_type shadow_reg, shadow_next;
  logic shadow_we_reg, shadow_we_next;
  logic [7:0] call_low_reg, call_low_next;

  function automatic logic [pc_width-1:0] branch_target(
    input logic [pc_width-1:0] base, input logic [7:0] disp);
    logic [pc_width-1:0] ext;
    ext = {{(pc_width-8){disp[7]}}, disp};
    return base + pc_step_one + {ext[pc_width-2:0], 1'b0};
  endfunction : branch_target

  file_addr_resolve u_resolve (
    .bank_sel_bit(instr_word[8]),
    .bank_select_pointer(bank_select_pointer),
    .offset(instr_word[7:0]),
    .addr(faddr_comb)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    flush_next = 1'b0;
    file_we_next = 1'b0;
    faddr_next = faddr_reg;
    wdata_next = wdata_reg;
    push_next = 1'b0;
    tos_next = tos_reg;
    shadow_next = shadow_reg;
    shadow_we_next = 1'b0;
    call_low_next = call_low_reg;
    unique case (state_reg)
      exec_normal: begin
        if (instr_valid) begin
          pc_next = pc_reg + pc_step_one;
          if (instr_word[15:12] == op_invert_bit) begin
            faddr_next = faddr_comb;
            wdata_next = file_rdata ^ data_width'(1 << instr_word[11:9]);
            file_we_next = 1'b1;
          end else if (instr_word[15:8] == op_branch_ov) begin
            if (flags_register[flag_ovf_pos]) begin
              pc_next = branch_target(pc_reg, instr_word[7:0]);
              flush_next = 1'b1;
              state_next = exec_flush;
            end
          end else if (instr_word[15:8] == op_branch_zero) begin
            if (flags_register[flag_zero_pos]) begin
              pc_next = branch_target(pc_reg, instr_word[7:0]);
              flush_next = 1'b1;
              state_next = exec_flush;
            end
          end else if (instr_word[15:9] == op_call_first) begin
            tos_next = pc_reg + pc_step_call;
            push_next = 1'b1;
            call_low_next = instr_word[7:0];
            if (instr_word[8]) begin
              shadow_next = '{working: working_register, flags: flags_register,
                              bank: bank_select_pointer};
              shadow_we_next = 1'b1;
            end
            state_next = exec_call_second;
          end
        end
      end
      exec_flush: begin
        state_next = exec_normal;
      end
      exec_call_second: begin
        if (instr_valid && instr_word[15:12] == op_second_word) begin
          pc_next = {instr_word[11:0], call_low_reg, 1'b0};
          flush_next = 1'b1;
          state_next = exec_normal;
        end
      end
      default: state_next = exec_normal;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= exec_normal;
      pc_reg <= pc_reset_value;
      flush_reg <= 1'b0;
      file_we_reg <= 1'b0;
      faddr_reg <= '0;
      wdata_reg <= '0;
      push_reg <= 1'b0;
      tos_reg <= '0;
      shadow_reg <= '0;
      shadow_we_reg <= 1'b0;
      call_low_reg <= '0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      flush_reg <= flush_next;
      file_we_reg <= file_we_next;
      faddr_reg <= faddr_next;
      wdata_reg <= wdata_next;
      push_reg <= push_next;
      tos_reg <= tos_next;
      shadow_reg <= shadow_next;
      shadow_we_reg <= shadow_we_next;
      call_low_reg <= call_low_next;
    end
  end

  // No flags output: status flags untouched by this block
  assign pc = pc_reg;
  assign flush = flush_reg;
  assign file_we = file_we_reg;
  assign file_addr = faddr_reg;
  assign file_wdata = wdata_reg;
  assign stack_push = push_reg;
  assign return_stack_top = tos_reg;
  assign shadow = shadow_reg;
  assign shadow_we = shadow_we_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_invert_one_bit: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid && instr_word[15:12] == op_invert_bit)
    |=> file_we && $countones(file_wdata ^ $past(file_rdata)) == 1)
    else $error("bit invert changed wrong bits");
  a_bank_access: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid && instr_word[15:12] == op_invert_bit
     && !instr_word[8]) |=> file_addr.bank == access_bank)
    else $error("access bank not forced");
  a_ovf_branch: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid && instr_word[15:8] == op_branch_ov
     && !flags_register[flag_ovf_pos]) |=> !flush && pc == $past(pc) + pc_step_one)
    else $error("overflow branch taken wrongly");
  a_zero_branch: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid && instr_word[15:8] == op_branch_zero
     && flags_register[flag_zero_pos]) |=> flush)
    else $error("zero branch not taken");
  a_flush_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    flush && state_reg == exec_flush |=> !flush && !file_we && !stack_push)
    else $error("flush cycle not idle");
  a_call_push: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid && instr_word[15:9] == op_call_first)
    |=> stack_push && return_stack_top == $past(pc) + pc_step_call)
    else $error("call push wrong");
  a_shadow_copy: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid && instr_word[15:9] == op_call_first)
    |=> shadow_we == $past(instr_word[8]))
    else $error("shadow copy mismatch");
  a_call_target: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_call_second && instr_valid && instr_word[15:12] == op_second_word)
    |=> pc[8:0] == {$past(call_low_reg), 1'b0} && pc[20:9] == $past(instr_word[11:0]))
    else $error("call target wrong");
  a_branch_target: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid
     && (instr_word[15:8] == op_branch_ov && flags_register[flag_ovf_pos]
      || instr_word[15:8] == op_branch_zero && flags_register[flag_zero_pos]))
    |=> flush && pc == $past(pc) + pc_step_one
      + {{(pc_width-9){$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0})
    else $error("branch target wrong");
  a_zero_untaken: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_normal && instr_valid && instr_word[15:8] == op_branch_zero
     && !flags_register[flag_zero_pos]) |=> !flush && pc == $past(pc) + pc_step_one)
    else $error("zero branch taken wrongly");
  a_flush_ignore: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_reg == exec_flush |=> !file_we && !stack_push && !shadow_we && $stable(pc))
    else $error("flush cycle not ignored");
  a_call_wait: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_call_second && !(instr_valid && instr_word[15:12] == op_second_word))
    |=> state_reg == exec_call_second && !flush && !file_we && $stable(pc))
    else $error("call wait not idle");
  a_call_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_reg == exec_call_second && instr_valid && instr_word[15:12] == op_second_word)
    |=> flush && !file_we && !stack_push && !shadow_we)
    else $error("call second cycle not idle");
endmodule : core_exec
`default_nettype wire

// file: core_exec_pkg.sv
package core_exec_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int pc_width = 21;
  localparam int data_width = 8;
  localparam int file_addr_width = 8;
  localparam int bank_width = 4;
  localparam int word_width = 16;
  // ----------------------------------------
  // Opcode fields and fixed constants
  // ----------------------------------------
  localparam logic [3:0] op_invert_bit = 4'h7;
  localparam logic [7:0] op_branch_ov = 8'he4;
  localparam logic [7:0] op_branch_zero = 8'he0;
  localparam logic [6:0] op_call_first = 7'h76;
  localparam logic [3:0] op_second_word = 4'hf;
  localparam logic [3:0] access_bank = 4'h0;
  localparam logic [pc_width-1:0] pc_step_one = 21'h000002;
  localparam logic [pc_width-1:0] pc_step_call = 21'h000004;
  localparam logic [pc_width-1:0] pc_reset_value = 21'h000000;
  // Flag bit positions in the flags register
  localparam int flag_zero_pos = 2;
  localparam int flag_ovf_pos = 3;

  typedef enum logic [1:0] {
    exec_normal,
    exec_flush,
    exec_call_second
  } exec_state_type;

  typedef struct packed {
    logic [bank_width-1:0] bank;
    logic [file_addr_width-1:0] offset;
  } file_addr_type;

  typedef struct packed {
    logic [data_width-1:0] working;
    logic [data_width-1:0] flags;
    logic [bank_width-1:0] bank;
  } shadow_type;
endpackage : core_exec_pkg

// file: file_addr_resolve.sv
`timescale 1ns/10ps
`default_nettype none
module file_addr_resolve import core_exec_pkg::*; (
  input wire logic bank_sel_bit,
  input wire logic [bank_width-1:0] bank_select_pointer,
  input wire logic [file_addr_width-1:0] offset,
  output file_addr_type addr
);
  // ----------------------------------------
  // Bank selection
  // ----------------------------------------
  always_comb begin
    addr.offset = offset;
    addr.bank = bank_sel_bit ? bank_select_pointer : access_bank;
  end
endmodule : file_addr_resolve
`default_nettype wire

// file: testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench import core_exec_pkg::*;;
  // ----------------------------------------
  // Stimulus and design
  // ----------------------------------------
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic instr_valid = 1'b0;
  logic [word_width-1:0] instr_word = 16'h0000;
  logic [data_width-1:0] working_register = 8'h00;
  logic [data_width-1:0] flags_register = 8'h00;
  logic [bank_width-1:0] bank_select_pointer = 4'h0;
  logic [data_width-1:0] file_rdata = 8'h00;
  logic [pc_width-1:0] pc;
  logic [pc_width-1:0] return_stack_top;
  logic flush, file_we, stack_push, shadow_we;
  file_addr_type file_addr;
  logic [data_width-1:0] file_wdata;
  shadow_type shadow;
  logic [pc_width-1:0] exp_pc = 21'h000000;
  int err_total = 0;
  int checks = 0;
  int cycles = 0;
  always #10 sys_clk = ~sys_clk;
  core_exec core_exec_i (.sys_clk(sys_clk), .rstn(rstn), .instr_valid(instr_valid),
    .instr_word(instr_word), .working_register(working_register),
    .flags_register(flags_register), .bank_select_pointer(bank_select_pointer),
    .file_rdata(file_rdata), .pc(pc), .flush(flush), .file_we(file_we),
    .file_addr(file_addr), .file_wdata(file_wdata), .stack_push(stack_push),
    .return_stack_top(return_stack_top), .shadow(shadow), .shadow_we(shadow_we));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk_val(input string what, input logic [20:0] exp, input logic [20:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val
  task automatic chk_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_flag
  // Drives one edge; results of the word taken at that edge show on return
  task automatic step(input logic v, input logic [word_width-1:0] w);
    @(posedge sys_clk);
    instr_valid <= v;
    instr_word <= w;
    @(negedge sys_clk);
  endtask : step
  task automatic invert_case(input logic [2:0] b, input logic a, input logic [7:0] f);
    logic [7:0] rd;
    rd = f ^ 8'h5a;
    @(posedge sys_clk);
    file_rdata <= rd;
    bank_select_pointer <= {1'b1, b};
    step(1'b1, {op_invert_bit, b, a, f});
    step(1'b0, 16'h0000);
    exp_pc += pc_step_one;
    chk_flag("file_we", 1'b1, file_we);
    chk_val("wdata", {13'h0000, rd ^ (8'h01 << b)}, {13'h0000, file_wdata});
    chk_val("addr", {9'h000, a ? {1'b1, b} : access_bank, f}, {9'h000, file_addr});
    chk_val("pc", exp_pc, pc);
  endtask : invert_case
  task automatic branch(input logic [7:0] op, input logic [7:0] fl, input logic [7:0] n);
    logic taken;
    taken = (op == op_branch_ov) ? fl[flag_ovf_pos] : fl[flag_zero_pos];
    @(posedge sys_clk);
    flags_register <= fl;
    step(1'b1, {op, n});
    step(1'b1, 16'h7000);
    exp_pc += pc_step_one;
    if (taken) exp_pc += {{12{n[7]}}, n, 1'b0};
    chk_val("pc", exp_pc, pc);
    chk_flag("flush", taken, flush);
    step(1'b0, 16'h0000);
    if (!taken) exp_pc += pc_step_one;
    chk_flag("file_we", !taken, file_we);
    chk_flag("flush", 1'b0, flush);
    chk_val("pc", exp_pc, pc);
  endtask : branch
  task automatic call(input logic s, input logic [19:0] k, input logic gap);
    @(posedge sys_clk);
    working_register <= 8'ha5;
    flags_register <= 8'h3c;
    bank_select_pointer <= 4'h6;
    step(1'b1, {op_call_first, s, k[7:0]});
    step(1'b1, gap ? 16'h7000 : {op_second_word, k[19:8]});
    chk_flag("push", 1'b1, stack_push);
    chk_val("tos", exp_pc + pc_step_call, return_stack_top);
    chk_flag("shadow_we", s, shadow_we);
    if (s) chk_val("shadow", {1'b0, 8'ha5, 8'h3c, 4'h6}, {1'b0, shadow});
    exp_pc += pc_step_one;
    if (gap) begin
      step(1'b1, {op_second_word, k[19:8]});
      chk_flag("file_we", 1'b0, file_we);
      chk_val("pc", exp_pc, pc);
    end
    step(1'b0, 16'h0000);
    exp_pc = {k, 1'b0};
    chk_val("pc", exp_pc, pc);
    chk_flag("flush", 1'b1, flush);
    chk_flag("push", 1'b0, stack_push);
    step(1'b0, 16'h0000);
    chk_flag("flush", 1'b0, flush);
    chk_val("pc", exp_pc, pc);
  endtask : call
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(negedge sys_clk);
    chk_val("pc", pc_reset_value, pc);
    for (int i = 0; i < 8; i++) invert_case(i[2:0], i[0], 8'(i * 37));
    branch(op_branch_ov, 8'h08, 8'h7f);
    branch(op_branch_ov, 8'hf7, 8'h10);
    branch(op_branch_zero, 8'h04, 8'h80);
    branch(op_branch_zero, 8'hfb, 8'h01);
    call(1'b1, 20'hfffff, 1'b1);
    call(1'b0, 20'h12345, 1'b0);
    branch(op_branch_zero, 8'h04, 8'h80);
    test_done();
  end
endmodule : testbench
`default_nettype wire
